// ---- design/drive_state_machine.sv ----
// drive power state machine stepped by the command word
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - command word bit layout, reserved high bits
// - shutdown, disable voltage, quick stop transitions
// - switch on, disable and enable operation
// - switch-on gated by five permissive conditions
// - power-up then automatic init completion
// - quick stop waits stop, then disabled
// - alarm goes fault-reaction then fault
// - switched-on stopped, lost permissive -> ready
// - enabled stopped, lost permissive -> ready, off
// - network lost while moving raises 81h
// - main power lost while moving raises 23h
// - removal or release while moving -> ready
// - quick-stop lost permissive -> disabled, off
// - fault reset acts on rising edge only
// - status word pattern per state
// - 250 ms excitation before motion ready
module drive_state_machine #(
  parameter int EXCITE_CNT = dsm_pkg::EXCITE_CYCLES
) (
  input  wire logic                      ref_clk,
  input  wire logic                      rst,
  input  wire logic [dsm_pkg::CMD_W-1:0] cmd_word,
  input  wire logic                      cmd_write,
  input  wire logic                      init_done,
  input  wire logic [3:0]                qs_option,
  input  wire dsm_pkg::drive_cond_t      cond_raw,
  output var  dsm_pkg::drive_out_t       drv_out,
  output var  dsm_pkg::dsm_state_t       state_out,
  output var  logic [dsm_pkg::CMD_W-1:0] cmd_readback
);
  import dsm_pkg::*;

  // ==========================================
  // state record
  typedef struct packed {
    drive_cond_t  sync1;
    drive_cond_t  sync2;
    logic         init1;
    logic         init2;
    logic [15:0]  cmd;
    logic         fr_prev;
    dsm_state_t   st;
    logic [31:0]  cnt;
    drive_out_t   out;
  } dsm_reg_t;

  dsm_reg_t r_r;
  dsm_reg_t r_nxt;

  function automatic logic [6:0] status_of(input dsm_state_t s);
    case (s)
      ST_NOT_READY:   status_of = SW_NOT_READY;
      ST_SO_DISABLED: status_of = SW_SO_DISABLED;
      ST_READY:       status_of = SW_READY;
      ST_SWITCHED_ON: status_of = SW_SWITCHED_ON;
      ST_OP_ENABLED:  status_of = SW_OP_ENABLED;
      ST_QSTOP:       status_of = SW_QSTOP;
      ST_FAULT_REACT: status_of = SW_FAULT_REACT;
      ST_FAULT:       status_of = SW_FAULT;
      default:        status_of = SW_NOT_READY;
    endcase
  endfunction

  logic        sw_on;
  logic        en_v;
  logic        qs_n;
  logic        en_op;
  logic        fr_edge;
  logic        lost;
  logic        permit;
  logic        mov;
  drive_cond_t c;
  dsm_state_t  ns;

  // next-state logic
  always_comb begin
    r_nxt = r_r;
    r_nxt.sync1 = cond_raw;
    r_nxt.sync2 = r_r.sync1;
    r_nxt.init1 = init_done;
    r_nxt.init2 = r_r.init1;
    c = r_r.sync2;
    // latch command word, high bits kept as written
    if (cmd_write) begin
      r_nxt.cmd = cmd_word;
    end
    sw_on = r_r.cmd[B_SWITCH_ON];
    en_v  = r_r.cmd[B_EN_VOLTAGE];
    qs_n  = r_r.cmd[B_QUICK_STOP];
    en_op = r_r.cmd[B_EN_OP];
    // rising edge of fault reset only
    fr_edge = r_r.cmd[B_FAULT_RESET] & ~r_r.fr_prev;
    r_nxt.fr_prev = r_r.cmd[B_FAULT_RESET];
    lost = ~c.net_operational | ~c.main_power | c.power_removal
         | c.motor_release;
    permit = c.net_operational & c.main_power & ~c.motor_release
           & ~c.torque_off_monitor_output & ~c.test_operation;
    mov = c.motor_moving;
    ns = r_r.st;
    case (r_r.st)
      ST_NOT_READY: begin
        if (r_r.init2) ns = ST_SO_DISABLED;
      end
      ST_SO_DISABLED: begin
        if (en_v & qs_n & ~sw_on) ns = ST_READY;
      end
      // ready drops to disabled on disable voltage or quick stop, ahead of switch on
      ST_READY: begin
        if (~en_v | ~qs_n) ns = ST_SO_DISABLED;
        else if (sw_on & permit) ns = en_op ? ST_OP_ENABLED
                                            : ST_SWITCHED_ON;
      end
      ST_SWITCHED_ON: begin
        if (lost & ~mov) ns = ST_READY;
        else if (~en_v | ~qs_n) ns = ST_SO_DISABLED;
        else if (~sw_on) ns = ST_READY;
        else if (en_op) ns = ST_OP_ENABLED;
      end
      ST_OP_ENABLED: begin
        if (mov & ~c.net_operational) begin
          ns = ST_FAULT_REACT;
          r_nxt.out.alarm_code = ALM_NET_BUS;
        end else if (mov & ~c.main_power) begin
          ns = ST_FAULT_REACT;
          r_nxt.out.alarm_code = ALM_MAIN_PW;
        end else if (c.alarm_present) begin
          ns = ST_FAULT_REACT;
        end else if (lost) begin
          ns = ST_READY;
        end else if (~en_v) begin
          ns = ST_SO_DISABLED;
        end else if (~qs_n) begin
          ns = ST_QSTOP;
        end else if (~sw_on) begin
          ns = ST_READY;
        end else if (~en_op) begin
          ns = ST_SWITCHED_ON;
        end
      end
      ST_QSTOP: begin
        if (mov & ~c.net_operational) begin
          ns = ST_FAULT_REACT;
          r_nxt.out.alarm_code = ALM_NET_BUS;
        end else if (mov & ~c.main_power) begin
          ns = ST_FAULT_REACT;
          r_nxt.out.alarm_code = ALM_MAIN_PW;
        end else if (c.alarm_present) begin
          ns = ST_FAULT_REACT;
        end else if (lost) begin
          ns = ST_SO_DISABLED;
        end else if (~en_v) begin
          ns = ST_SO_DISABLED;
        end else if (~mov & qs_option >= QS_OPT_MIN
                     & qs_option <= QS_OPT_MAX) begin
          ns = ST_SO_DISABLED;
        end else if (qs_n & sw_on & en_op) begin
          ns = ST_OP_ENABLED;
        end
      end
      ST_FAULT_REACT: begin
        if (~mov) ns = ST_FAULT;
      end
      // leave only with no alarm present
      ST_FAULT: begin
        if (fr_edge & ~c.alarm_present & c.net_operational
            & c.main_power) begin
          ns = ST_SO_DISABLED;
          r_nxt.out.alarm_code = ALM_NONE;
        end
      end
      default: ns = ST_NOT_READY;
    endcase
    // alarm in powered states starts reaction
    if (c.alarm_present & r_r.st != ST_NOT_READY
        & r_r.st != ST_FAULT_REACT & r_r.st != ST_FAULT) begin
      ns = ST_FAULT_REACT;
    end
    r_nxt.st = ns;
    if (ns == ST_OP_ENABLED & r_r.st != ST_OP_ENABLED) begin
      r_nxt.cnt = 32'h0;
    end else if (ns == ST_OP_ENABLED & r_r.cnt < 32'(EXCITE_CNT)) begin
      r_nxt.cnt = r_r.cnt + 32'h1;
    end
    r_nxt.out.motion_ready = ns == ST_OP_ENABLED
                           & r_nxt.cnt >= 32'(EXCITE_CNT);
    r_nxt.out.excited = ns == ST_OP_ENABLED | ns == ST_QSTOP
                      | ns == ST_FAULT_REACT;
    // status word from state plus voltage bit
    r_nxt.out.status_word = {9'h000, status_of(ns)};
    r_nxt.out.status_word[VOLT_BIT] = c.main_power & (ns != ST_NOT_READY);
  end

  // register the record
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      r_r <= '0;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign drv_out      = r_r.out;
  assign state_out    = r_r.st;
  assign cmd_readback = r_r.cmd;

  // ==========================================
  // checks
  sequence s_moving_netloss;
    (r_r.st == ST_OP_ENABLED) && r_r.sync2.motor_moving
      && !r_r.sync2.net_operational;
  endsequence

  a_net_alarm_code: assert property (@(posedge ref_clk) disable iff (rst)
    s_moving_netloss |=> (r_r.st == ST_FAULT_REACT)
      && (r_r.out.alarm_code == ALM_NET_BUS))
    else $error("network loss while moving gave no 81h");
  a_main_alarm_code: assert property (@(posedge ref_clk) disable iff (rst)
    (r_r.st == ST_OP_ENABLED) && r_r.sync2.motor_moving
      && r_r.sync2.net_operational && !r_r.sync2.main_power
      |=> r_r.out.alarm_code == ALM_MAIN_PW)
    else $error("main power loss while moving gave no 23h");
  a_permit_gate: assert property (@(posedge ref_clk) disable iff (rst)
    (r_r.st == ST_READY) && !permit
      |=> r_r.st != ST_SWITCHED_ON && r_r.st != ST_OP_ENABLED)
    else $error("switched on without permissives");
  a_fault_level: assert property (@(posedge ref_clk) disable iff (rst)
    (r_r.st == ST_FAULT) && $stable(r_r.cmd[B_FAULT_RESET])
      && $past(r_r.cmd[B_FAULT_RESET]) |=> r_r.st == ST_FAULT)
    else $error("fault left without reset edge");
  a_fault_alarm: assert property (@(posedge ref_clk) disable iff (rst)
    (r_r.st == ST_FAULT) && r_r.sync2.alarm_present
      |=> r_r.st == ST_FAULT)
    else $error("fault left while alarm present");
  a_status_map: assert property (@(posedge ref_clk) disable iff (rst)
    (r_r.out.status_word[6:0] & ~7'(1 << VOLT_BIT)) == status_of(r_r.st)
      && r_r.out.status_word[VOLT_BIT]
         == ($past(r_r.sync2.main_power) && r_r.st != ST_NOT_READY))
    else $error("status word does not match state");
  a_alarm_react: assert property (@(posedge ref_clk) disable iff (rst)
    r_r.sync2.alarm_present && (r_r.st inside {ST_SO_DISABLED, ST_READY,
      ST_SWITCHED_ON, ST_OP_ENABLED, ST_QSTOP}) |=> r_r.st == ST_FAULT_REACT)
    else $error("alarm did not start fault reaction");
  a_ready_delay: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(r_r.st == ST_OP_ENABLED) |-> !r_r.out.motion_ready)
    else $error("motion ready too early");
  a_shutdown_ready: assert property (@(posedge ref_clk) disable iff (rst)
    (r_r.st == ST_SO_DISABLED) && r_r.cmd[2:0] == 3'b110
      |=> r_r.st == ST_READY)
    else $error("shutdown did not reach ready");
  a_switched_stop: assert property (@(posedge ref_clk) disable iff (rst)
    (r_r.st == ST_SWITCHED_ON) && lost && !mov |=> r_r.st == ST_READY)
    else $error("switched on kept despite lost permissive");
endmodule
`default_nettype wire

// ---- shared/dsm_pkg.sv ----
// package: drive state machine constants, states and carriers
package dsm_pkg;
  // ==========================================
  // command word fields
  localparam int CMD_W         = 16;
  localparam int B_SWITCH_ON   = 0;
  localparam int B_EN_VOLTAGE  = 1;
  localparam int B_QUICK_STOP  = 2;
  localparam int B_EN_OP       = 3;
  localparam int B_FAULT_RESET = 7;
  localparam int B_HALT        = 8;
  localparam logic [15:0] CMD_WORD_INDEX = 16'h6040;
  localparam logic [15:0] CMD_RESET      = 16'h0000;
  // ==========================================
  // alarm codes
  localparam logic [7:0] ALM_NONE    = 8'h00;
  localparam logic [7:0] ALM_NET_BUS = 8'h81;
  localparam logic [7:0] ALM_MAIN_PW = 8'h23;
  // quick-stop option range that waits for stop
  localparam logic [3:0] QS_OPT_MIN = 4'h1;
  localparam logic [3:0] QS_OPT_MAX = 4'h3;
  // ==========================================
  // timing
  localparam int CLK_HZ        = 100_000_000;
  localparam int EXCITE_MS     = 250;
  localparam int EXCITE_CYCLES = CLK_HZ / 1000 * EXCITE_MS;
  localparam int STAT_BITS_W   = 7;
  localparam int VOLT_BIT      = 4;
  // ==========================================
  // states
  typedef enum logic [2:0] {
    ST_NOT_READY   = 3'b000,
    ST_SO_DISABLED = 3'b001,
    ST_READY       = 3'b010,
    ST_SWITCHED_ON = 3'b011,
    ST_OP_ENABLED  = 3'b100,
    ST_QSTOP       = 3'b101,
    ST_FAULT_REACT = 3'b110,
    ST_FAULT       = 3'b111
  } dsm_state_t;
  // status patterns, bits 6..0, voltage bit zero
  localparam logic [6:0] SW_NOT_READY   = 7'h00;
  localparam logic [6:0] SW_SO_DISABLED = 7'h60;
  localparam logic [6:0] SW_READY       = 7'h21;
  localparam logic [6:0] SW_SWITCHED_ON = 7'h23;
  localparam logic [6:0] SW_OP_ENABLED  = 7'h27;
  localparam logic [6:0] SW_QSTOP       = 7'h07;
  localparam logic [6:0] SW_FAULT_REACT = 7'h2f;
  localparam logic [6:0] SW_FAULT       = 7'h28;
  // ==========================================
  // carriers
  typedef struct packed {
    logic net_operational;
    logic main_power;
    logic motor_release;
    logic torque_off_monitor_output;
    logic test_operation;
    logic power_removal;
    logic motor_moving;
    logic alarm_present;
  } drive_cond_t;
  typedef struct packed {
    logic [15:0] status_word;
    logic        excited;
    logic        motion_ready;
    logic [7:0]  alarm_code;
  } drive_out_t;
endpackage

// ---- test/drive_master.sv ----
// command master model that writes the drive command word
`timescale 1ns/1ps
`default_nettype none
module drive_master (
  input  wire logic        ref_clk,
  output var  logic [15:0] cmd_word,
  output var  logic        cmd_write
);
  // ==========================================
  // write one command word as a one-cycle pulse
  initial begin
    cmd_word  = 16'h0000;
    cmd_write = 1'b0;
  end
  // reserved and maker bits kept clear
  task automatic send(input logic [15:0] w);
    @(negedge ref_clk);
    cmd_word  = w & 16'h03ff;
    cmd_write = 1'b1;
    @(negedge ref_clk);
    cmd_write = 1'b0;
    cmd_word  = ~w; // stale value is not kept
  endtask
endmodule
`default_nettype wire

// ---- test/drive_state_machine_tb.sv ----
// self-checking bench for the drive state machine
`timescale 1ns/1ps
`default_nettype none
module drive_state_machine_tb;
  import dsm_pkg::*;
  typedef struct packed {
    dsm_state_t st;
    logic [7:0] alm;
  } note_t;
  logic        ref_clk   = 1'b0;
  logic        rst       = 1'b1;
  logic        init_done = 1'b0;
  logic [3:0]  qs_option = 4'h2;
  drive_cond_t cond      = '0;
  drive_cond_t good      = 8'hc0;
  drive_out_t  drv_out;
  dsm_state_t  state_out;
  dsm_state_t  last_st   = ST_NOT_READY;
  logic [15:0] cmd_word;
  logic        cmd_write;
  logic [15:0] cmd_rb;
  note_t       notes[$];
  note_t       n;
  int          num_errors = 0;
  int          checks     = 0;
  int          cycles     = 0;
  int          k;
  always #5 ref_clk = ~ref_clk;
  drive_state_machine #(.EXCITE_CNT(20)) dut (
    .ref_clk(ref_clk), .rst(rst), .cmd_word(cmd_word),
    .cmd_write(cmd_write), .init_done(init_done), .qs_option(qs_option),
    .cond_raw(cond), .drv_out(drv_out), .state_out(state_out),
    .cmd_readback(cmd_rb));
  drive_master master (
    .ref_clk(ref_clk), .cmd_word(cmd_word), .cmd_write(cmd_write));
  // ==========================================
  // helpers
  task automatic check(string nm, logic [15:0] seen, logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  function automatic logic [6:0] stat(dsm_state_t s, logic mp);
    logic [6:0] v;
    case (s)
      ST_SO_DISABLED: v = SW_SO_DISABLED;
      ST_READY:       v = SW_READY;
      ST_SWITCHED_ON: v = SW_SWITCHED_ON;
      ST_OP_ENABLED:  v = SW_OP_ENABLED;
      ST_QSTOP:       v = SW_QSTOP;
      ST_FAULT_REACT: v = SW_FAULT_REACT;
      ST_FAULT:       v = SW_FAULT;
      default:        v = 7'h00;
    endcase
    return v | {2'h0, mp & (s != ST_NOT_READY), 4'h0};
  endfunction
  task automatic note(dsm_state_t s, logic [7:0] a = 8'h00);
    notes.push_back('{s, a});
  endtask
  // wait until every noted change was seen, bounded
  task automatic drain();
    repeat (6) @(negedge ref_clk);
    for (k = 0; k < 60 && notes.size() != 0; k++) @(negedge ref_clk);
    check("pending", 16'(notes.size()), 16'h0000);
  endtask
  task automatic go(logic [15:0] w, dsm_state_t s, bit en);
    if (en) note(s);
    master.send(w);
    drain();
    check("readback", cmd_rb, w & 16'h03ff);
  endtask
  // drop one random permissive
  task automatic lose();
    case ($urandom_range(3, 0))
      0: cond.net_operational = 1'b0;
      1: cond.main_power = 1'b0;
      2: cond.power_removal = 1'b1;
      default: cond.motor_release = 1'b1;
    endcase
  endtask
  task automatic end_of_test();
    if (num_errors == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ==========================================
  // monitor: each state change takes the oldest note
  always @(posedge ref_clk) begin
    #2;
    if (!rst && state_out !== last_st) begin
      last_st = state_out;
      n = (notes.size() != 0) ? notes.pop_front() : '1;
      check("state", {13'h0, state_out}, {13'h0, n.st});
      check("status", drv_out.status_word,
            {9'h0, stat(n.st, cond.main_power)});
      if (n.st == ST_FAULT)
        check("alarm", {8'h0, drv_out.alarm_code}, {8'h0, n.alm});
    end
  end
  // timeout guard
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      end_of_test();
    end
  end
  // ==========================================
  // main sequence
  initial begin
    void'($urandom(13306));
    repeat (12) @(posedge ref_clk);
    @(negedge ref_clk);
    rst = 1'b0;
    // held not ready, then init completes unaided
    cond = good;
    repeat (5) @(negedge ref_clk);
    check("state", {13'h0, state_out}, {13'h0, ST_NOT_READY});
    check("status", drv_out.status_word, 16'h0000);
    note(ST_SO_DISABLED);
    init_done = 1'b1;
    drain();
    go(16'h0006, ST_READY, 1);
    for (int i = 0; i < 5; i++) begin
      cond = good ^ (8'h80 >> i);
      go(16'h000f, ST_READY, 0);
    end
    cond = good;
    go(16'h0007, ST_SWITCHED_ON, 1);
    go(16'h000f, ST_OP_ENABLED, 1);
    check("motion_ready", {15'h0, drv_out.motion_ready}, 16'h0000);
    check("excited", {15'h0, drv_out.excited}, 16'h0001);
    repeat (25) @(negedge ref_clk);
    check("motion_ready", {15'h0, drv_out.motion_ready}, 16'h0001);
    go(16'h0007, ST_SWITCHED_ON, 1);
    go(16'h000f, ST_OP_ENABLED, 1);
    // quick stop holds until motor stops
    qs_option = 4'($urandom_range(3, 1));
    cond.motor_moving = 1'b1;
    go(16'h000b, ST_QSTOP, 1);
    note(ST_SO_DISABLED);
    cond.motor_moving = 1'b0;
    drain();
    go(16'h0006, ST_READY, 1);
    go(16'h000f, ST_OP_ENABLED, 1);
    note(ST_READY);
    lose();
    drain();
    check("excited", {15'h0, drv_out.excited}, 16'h0000);
    cond = good;
    go(16'h000f, ST_OP_ENABLED, 1);
    // removal or release while moving, no alarm
    cond.motor_moving = 1'b1;
    note(ST_READY);
    if ($urandom_range(1, 0)) cond.power_removal = 1'b1;
    else cond.motor_release = 1'b1;
    drain();
    check("excited", {15'h0, drv_out.excited}, 16'h0000);
    check("alarm", {8'h0, drv_out.alarm_code}, {8'h0, ALM_NONE});
    for (int j = 0; j < 2; j++) begin
      cond = good;
      go(16'h000f, ST_OP_ENABLED, 1);
      cond.motor_moving = 1'b1;
      note(ST_FAULT_REACT);
      note(ST_FAULT, j ? ALM_MAIN_PW : ALM_NET_BUS);
      if (j) cond.main_power = 1'b0;
      else cond.net_operational = 1'b0;
      repeat (10) @(negedge ref_clk);
      cond.motor_moving = 1'b0;
      drain();
      check("excited", {15'h0, drv_out.excited}, 16'h0000);
      go(16'h0080, ST_FAULT, 0);
      cond = good;
      // bit held high gives no edge
      go(16'h0080, ST_FAULT, 0);
      go(16'h0000, ST_FAULT, 0);
      go(16'h0080, ST_SO_DISABLED, 1);
      go(16'h0006, ST_READY, 1);
    end
    // plain alarm with motor stopped ends in fault
    go(16'h000f, ST_OP_ENABLED, 1);
    note(ST_FAULT_REACT);
    note(ST_FAULT, ALM_NONE);
    cond.alarm_present = 1'b1;
    drain();
    // reset edge refused while alarm remains
    go(16'h0080, ST_FAULT, 0);
    cond.alarm_present = 1'b0;
    go(16'h0000, ST_FAULT, 0);
    go(16'h0080, ST_SO_DISABLED, 1);
    // option outside the waiting range holds quick stop
    go(16'h0006, ST_READY, 1);
    go(16'h000f, ST_OP_ENABLED, 1);
    qs_option = 4'h0;
    go(16'h000b, ST_QSTOP, 1);
    go(16'h000f, ST_OP_ENABLED, 1);
    go(16'h000b, ST_QSTOP, 1);
    // lost permissive in quick stop -> disabled, off
    note(ST_SO_DISABLED);
    lose();
    drain();
    check("excited", {15'h0, drv_out.excited}, 16'h0000);
    end_of_test();
  end
endmodule
`default_nettype wire
